/* File: verilog/flash_status_one.sv */
`timescale 1ns/10ps
// Functional notes
// - opcode 05h, read-any, write-any reach register
// - bit 7 mirrors stored write lock
// - program failure or protected target sets bit 6
// - erase failure or protected sector sets bit 5
// - blocked bulk erase sets no erase error; failed bulk erase does
// - error flags cleared by clear-status, or reloaded from stored bits by reset
// - select 0: write stored, copy to volatile
// - select 1: write only volatile protect bits
// - protected range refuses program and erase
// - bulk erase only with protect bits zero
// - writes, program, erase need latch set
// - write-enable 06h sets latch
// - write-disable 04h clears latch
// - successful operation end clears latch
// - any reset clears latch
// - only enable, disable, successful end, register write and reset change latch
// - busy flag shows running operation
// - busy accepts only listed commands
// - suspend only during array operation
// - error keeps busy, refuses new operations
// - clear-status leaves error-held busy state
// - reset loads defaults from stored bits
// - lock and low protect pin block writes
module flash_status_one
   import flash_status_pkg::*;
#(
   parameter logic [7:0] PROG_OP = 8'h02,
   parameter logic [7:0] OTP_PROG_OP = 8'h42,
   parameter logic [7:0] ERASE_OP = 8'hD8,
   parameter logic [7:0] BULK_OP = 8'h60,
   parameter logic [7:0] SOFT_RST_OP = 8'hF0,
   parameter logic [23:0] VOL_ADDR = 24'h80_0000,
   parameter logic [23:0] STORED_ADDR = 24'h00_0000,
   parameter bit PROTECT_FROM_BOTTOM = 1'b0
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_si_i,
   input wire logic wp_n_i,
   input wire logic hw_rst_n_i,
   input wire logic [7:0] status_one_stored_i,
   input wire logic [7:0] config_one_stored_i,
   input wire logic otp_locked_i,
   input wire logic array_done_i,
   input wire logic array_fail_i,
   output logic spi_so_o,
   output logic spi_so_oe_o,
   output logic stored_write_o,
   output logic [7:0] stored_data_o,
   output logic array_start_o,
   output array_req_t array_req_o,
   output logic suspend_o,
   output logic [7:0] status_one_volatile_o
);
   // pin synchronisers; third sck and cs stage only for edges
   logic sck_s1_r, sck_s2_r, sck_s3_r;
   logic cs_s1_r, cs_s2_r, cs_s3_r;
   logic si_s1_r, si_s2_r, wp_s1_r, wp_s2_r, hw_s1_r, hw_s2_r;

   always_ff @(posedge clk_i) begin
      sck_s1_r <= spi_sck_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      cs_s1_r <= spi_cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      si_s1_r <= spi_si_i;
      si_s2_r <= si_s1_r;
      wp_s1_r <= wp_n_i;
      wp_s2_r <= wp_s1_r;
      hw_s1_r <= hw_rst_n_i;
      hw_s2_r <= hw_s1_r;
   end

   frame_state_t fst_r;
   spi_cmd_t cmd_r;
   logic [2:0] bitcnt_r, outcnt_r;
   logic [1:0] bytecnt_r;
   logic [6:0] rx_r;
   logic [7:0] out_r;
   logic rd_status_r, so_r, so_oe_r;
   logic wel_r, busy_r, perr_r, eerr_r, lockcopy_r;
   logic [2:0] bp_r;
   array_kind_t kind_r;
   logic start_r, susp_r, stw_r;
   logic [7:0] stdata_r;
   array_req_t req_r;

   wire sck_rise = sck_s2_r & ~sck_s3_r & ~cs_s2_r;
   wire sck_fall = ~sck_s2_r & sck_s3_r & ~cs_s2_r;
   wire cs_rise = cs_s2_r & ~cs_s3_r;
   wire byte_end = sck_rise & (bitcnt_r == LAST_BIT);
   wire [7:0] rx_byte = {rx_r, si_s2_r};
   wire [23:0] full_addr = {cmd_r.addr[15:0], rx_byte};
   wire [7:0] status_now = {lockcopy_r, perr_r, eerr_r, bp_r, wel_r, busy_r};

   // command classes of the captured opcode
   wire [7:0] op = cmd_r.opcode;
   wire is_write_enable_cmd = op == OP_WR_EN;
   wire is_write_disable_cmd = op == OP_WR_DIS;
   wire is_clear_status_cmd = (op == OP_CLR_A) | (op == OP_CLR_B);
   wire is_wrr = op == OP_WR_REGS;
   wire is_write_any_register_cmd = op == OP_WR_ANY;
   wire is_susp = (op == OP_SUSP_A) | (op == OP_SUSP_B) | (op == OP_SUSP_C);
   wire is_prog = (op == PROG_OP) | (op == OTP_PROG_OP);
   wire is_erase = op == ERASE_OP;
   wire is_bulk = op == BULK_OP;
   wire is_srst = op == SOFT_RST_OP;
   wire busy_ok = is_clear_status_cmd | is_susp | is_srst;

   // execution happens at chip-select release with whole bytes only
   wire frame_ok = cs_rise & (fst_r == FR_SKIP) & (bitcnt_r == 3'h0);
   wire exec = frame_ok & (~busy_r | busy_ok);
   wire sel_vol = config_one_stored_i[SEL_BIT];
   wire [2:0] bp_act = sel_vol ? bp_r : status_one_stored_i[BP_HI:BP_LO];
   wire lock = status_one_stored_i[LOCK_BIT] & ~wp_s2_r;
   wire addr_hit = (cmd_r.addr == VOL_ADDR) | (cmd_r.addr == STORED_ADDR);
   wire reg_go = exec & wel_r & ~lock & (is_wrr | (is_write_any_register_cmd & addr_hit));
   wire prog_go = exec & wel_r & is_prog;
   wire erase_go = exec & wel_r & is_erase;
   wire bulk_go = exec & wel_r & is_bulk;
   wire write_enable_cmd_go = exec & is_write_enable_cmd;
   wire write_disable_cmd_go = exec & is_write_disable_cmd;
   wire clear_status_cmd_go = exec & is_clear_status_cmd;
   wire srst_go = exec & is_srst;
   wire in_array = (kind_r == ARR_PROG) | (kind_r == ARR_ERASE) | (kind_r == ARR_BULK);
   wire susp_go = exec & is_susp & busy_r & in_array & ~perr_r & ~eerr_r;
   wire rst_any = sys_rst_i | ~hw_s2_r | srst_go;
   wire prot_hit;
   wire prog_bad = prog_go & (prot_hit | ((op == OTP_PROG_OP) & otp_locked_i));
   wire erase_bad = erase_go & prot_hit;
   wire bulk_block = bulk_go & (bp_act != BP_NONE);
   wire start_go = (prog_go & ~prog_bad) | (erase_go & ~erase_bad) | (bulk_go & ~bulk_block);
   wire done_ok = busy_r & array_done_i & ~array_fail_i;
   wire done_bad = busy_r & array_done_i & array_fail_i;
   wire [7:0] wr_val = {cmd_r.data[LOCK_BIT], status_one_stored_i[PERR_BIT:EERR_BIT],
                        cmd_r.data[BP_HI:BP_LO], status_one_stored_i[WEL_BIT:BUSY_BIT]};

   flash_protect_map #(
      .ADDR_W(24),
      .FROM_BOTTOM(PROTECT_FROM_BOTTOM)
   ) u_map (
      .bp_i(bp_act),
      .addr_i(cmd_r.addr),
      .protected_o(prot_hit)
   );

   // frame sequencer
   always_ff @(posedge clk_i) begin
      if (rst_any || cs_s2_r) begin
         fst_r <= FR_OPCODE;
         bitcnt_r <= 3'h0;
         bytecnt_r <= 2'h0;
      end else if (sck_rise) begin
         bitcnt_r <= bitcnt_r + 3'h1;
         rx_r <= rx_byte[6:0];
         if (byte_end) begin
            case (fst_r)
               FR_OPCODE: begin
                  cmd_r.opcode <= rx_byte;
                  if (rx_byte == OP_RD_STATUS_ONE || rx_byte == OP_RD_STATUS_TWO)
                     fst_r <= FR_READ;
                  else if (rx_byte == OP_RD_ANY || rx_byte == OP_WR_ANY || rx_byte == PROG_OP ||
                           rx_byte == OTP_PROG_OP || rx_byte == ERASE_OP)
                     fst_r <= FR_ADDR;
                  else if (rx_byte == OP_WR_REGS)
                     fst_r <= FR_DATA;
                  else
                     fst_r <= FR_SKIP;
               end
               FR_ADDR: begin
                  cmd_r.addr <= full_addr;
                  bytecnt_r <= bytecnt_r + 2'h1;
                  if (bytecnt_r == LAST_ADDR_BYTE)
                     fst_r <= (op == OP_RD_ANY) ? FR_READ : ((op == OP_WR_ANY) ? FR_DATA : FR_SKIP);
               end
               FR_DATA: begin
                  cmd_r.data <= rx_byte;
                  fst_r <= FR_SKIP;
               end
               default: fst_r <= fst_r;
            endcase
         end
      end
   end

   // read path: status is re-sampled every byte, so polling sees live busy
   wire load_status = byte_end & ((fst_r == FR_OPCODE && rx_byte == OP_RD_STATUS_ONE) ||
                      (fst_r == FR_ADDR && bytecnt_r == LAST_ADDR_BYTE && op == OP_RD_ANY &&
                       full_addr == VOL_ADDR));
   wire load_zero = byte_end & ((fst_r == FR_OPCODE && rx_byte == OP_RD_STATUS_TWO) ||
                    (fst_r == FR_ADDR && bytecnt_r == LAST_ADDR_BYTE && op == OP_RD_ANY &&
                     full_addr != VOL_ADDR));

   always_ff @(posedge clk_i) begin
      if (rst_any || cs_s2_r) begin
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
         outcnt_r <= 3'h0;
         rd_status_r <= 1'b0;
      end else if (load_status || load_zero) begin
         out_r <= load_status ? status_now : ZERO_BYTE;
         rd_status_r <= load_status;
         outcnt_r <= 3'h0;
      end else if (sck_fall && fst_r == FR_READ) begin
         so_r <= out_r[7];
         so_oe_r <= 1'b1;
         outcnt_r <= outcnt_r + 3'h1;
         out_r <= (outcnt_r == LAST_BIT) ? (rd_status_r ? status_now : ZERO_BYTE) : {out_r[6:0], 1'b0};
      end
   end

   // write enable latch
   always_ff @(posedge clk_i) begin
      if (rst_any)
         wel_r <= 1'b0;
      else if (write_enable_cmd_go)
         wel_r <= 1'b1;
      else if (write_disable_cmd_go || done_ok || reg_go)
         wel_r <= 1'b0;
   end

   // busy and error flags; a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         busy_r <= status_one_stored_i[BUSY_BIT];
         perr_r <= status_one_stored_i[PERR_BIT];
         eerr_r <= status_one_stored_i[EERR_BIT];
         kind_r <= ARR_NONE;
      end else begin
         if (clear_status_cmd_go) begin
            perr_r <= 1'b0;
            eerr_r <= 1'b0;
            if (perr_r || eerr_r)
               busy_r <= 1'b0;
         end
         if (done_ok)
            busy_r <= 1'b0;
         if (prog_bad || (done_bad && kind_r == ARR_PROG))
            perr_r <= 1'b1;
         if (erase_bad || (done_bad && kind_r != ARR_PROG))
            eerr_r <= 1'b1;
         if (start_go || prog_bad || erase_bad)
            busy_r <= 1'b1;
         if (start_go)
            kind_r <= is_prog ? ARR_PROG : (is_erase ? ARR_ERASE : ARR_BULK);
      end
   end

   // protect bits and mirror; mirror tracks even through reset
   always_ff @(posedge clk_i) begin
      lockcopy_r <= status_one_stored_i[LOCK_BIT];
      if (rst_any || !sel_vol)
         bp_r <= (reg_go && !rst_any) ? cmd_r.data[BP_HI:BP_LO] : status_one_stored_i[BP_HI:BP_LO];
      else if (reg_go)
         bp_r <= cmd_r.data[BP_HI:BP_LO];
   end

   // requests toward array engine and stored register writer
   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         start_r <= 1'b0;
         susp_r <= 1'b0;
         stw_r <= 1'b0;
         stdata_r <= ZERO_BYTE;
         req_r <= '{kind: ARR_NONE, addr: 24'h00_0000};
      end else begin
         start_r <= start_go;
         susp_r <= susp_go;
         stw_r <= reg_go & ~sel_vol;
         if (reg_go)
            stdata_r <= wr_val;
         if (start_go)
            req_r <= '{kind: is_prog ? ARR_PROG : (is_erase ? ARR_ERASE : ARR_BULK), addr: cmd_r.addr};
      end
   end

   assign spi_so_o = so_r;
   assign spi_so_oe_o = so_oe_r;
   assign stored_write_o = stw_r;
   assign stored_data_o = stdata_r;
   assign array_start_o = start_r;
   assign array_req_o = req_r;
   assign suspend_o = susp_r;
   assign status_one_volatile_o = status_now;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_any);

   chk_write_enable_cmd_sets: assert property (write_enable_cmd_go |=> wel_r) else $error("latch not set");
   chk_write_disable_cmd_clears: assert property (write_disable_cmd_go |=> !wel_r) else $error("latch not cleared");
   chk_done_clears: assert property (done_ok |=> !wel_r && !busy_r) else $error("done kept state");
   chk_mirror_follows: assert property (1'b1 |=> lockcopy_r == $past(status_one_stored_i[LOCK_BIT]))
      else $error("lock mirror stale");
   // defaults may load an error while idle, so only a busy error must hold
   chk_error_holds: assert property (busy_r && (perr_r || eerr_r) && !clear_status_cmd_go |=> busy_r)
      else $error("busy dropped with error");
   chk_clear_status_cmd_clears: assert property (clear_status_cmd_go && !array_done_i |=>
      !perr_r && !eerr_r && (!busy_r || !$past(perr_r || eerr_r))) else $error("clear status failed");
   chk_bulk_guard: assert property (bulk_block && !array_done_i |=>
      !array_start_o && !eerr_r == !$past(eerr_r)) else $error("bulk erase not blocked");
   chk_wel_gate: assert property (frame_ok && (is_prog || is_erase || is_bulk) && !wel_r |=> !array_start_o)
      else $error("start without latch");
   chk_busy_filter: assert property (frame_ok && busy_r && is_write_enable_cmd && !wel_r |=> !wel_r)
      else $error("command taken while busy");
   chk_susp_gate: assert property (suspend_o |-> $past(busy_r) && $past(in_array))
      else $error("suspend without array op");
   chk_prot_error: assert property (prog_bad |=> perr_r && busy_r && !array_start_o)
      else $error("protected program not flagged");
   chk_lock_blocks: assert property (lock && frame_ok && is_wrr |=> !stored_write_o)
      else $error("locked write taken");
   chk_vol_select: assert property (reg_go && sel_vol |=>
      bp_r == $past(cmd_r.data[BP_HI:BP_LO]) && !stored_write_o) else $error("volatile write wrong");

   cov_read_status: cover property (load_status ##[1:200] sck_fall);
   cov_start: cover property (array_start_o);
   cov_err_clear: cover property (perr_r ##[1:500] clear_status_cmd_go);
   cov_bulk_block: cover property (bulk_block);
endmodule : flash_status_one

/* File: common/flash_status_pkg.sv */
package flash_status_pkg;
   // status one bit positions
   localparam int LOCK_BIT = 7;
   localparam int PERR_BIT = 6;
   localparam int EERR_BIT = 5;
   localparam int BP_HI = 4;
   localparam int BP_LO = 2;
   localparam int WEL_BIT = 1;
   localparam int BUSY_BIT = 0;
   // config one stored: block-protect volatility select
   localparam int SEL_BIT = 3;
   // command opcodes
   localparam logic [7:0] OP_RD_STATUS_ONE = 8'h05;
   localparam logic [7:0] OP_RD_STATUS_TWO = 8'h07;
   localparam logic [7:0] OP_WR_REGS = 8'h01;
   localparam logic [7:0] OP_WR_EN = 8'h06;
   localparam logic [7:0] OP_WR_DIS = 8'h04;
   localparam logic [7:0] OP_CLR_A = 8'h30;
   localparam logic [7:0] OP_CLR_B = 8'h82;
   localparam logic [7:0] OP_RD_ANY = 8'h65;
   localparam logic [7:0] OP_WR_ANY = 8'h71;
   localparam logic [7:0] OP_SUSP_A = 8'h75;
   localparam logic [7:0] OP_SUSP_B = 8'h85;
   localparam logic [7:0] OP_SUSP_C = 8'hB0;
   // frame geometry
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [2:0] BP_NONE = 3'h0;

   typedef enum {FR_OPCODE, FR_ADDR, FR_DATA, FR_READ, FR_SKIP} frame_state_t;
   typedef enum {ARR_NONE, ARR_PROG, ARR_ERASE, ARR_BULK} array_kind_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
   } spi_cmd_t;

   typedef struct packed {
      array_kind_t kind;
      logic [23:0] addr;
   } array_req_t;
endpackage : flash_status_pkg

/* File: verilog/flash_protect_map.sv */
`timescale 1ns/10ps
module flash_protect_map #(
   parameter int ADDR_W = 24,
   parameter bit FROM_BOTTOM = 1'b0
) (
   input wire logic [2:0] bp_i,
   input wire logic [ADDR_W-1:0] addr_i,
   output logic protected_o
);
   // each step doubles the protected span; 7 covers the whole array
   function automatic logic hit(input logic [2:0] bp, input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] mask;
      int span;
      span = ADDR_W - 7 + int'(bp);
      mask = '1;
      mask = mask << span;
      if (bp == 3'h0)
         return 1'b0;
      if (FROM_BOTTOM)
         return (a & mask) == '0;
      return (a & mask) == mask;
   endfunction : hit

   assign protected_o = hit(bp_i, addr_i);
endmodule : flash_protect_map

/* File: verification/flash_host.sv */
`timescale 1ns/10ps
module flash_host
   import flash_status_pkg::*;
(
   input wire logic clk_i,
   input wire logic spi_so_i,
   output logic spi_sck_o,
   output logic spi_cs_n_o,
   output logic spi_si_o
);
   // mode 0: clock idles low and stands still between frames
   initial begin
      spi_sck_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_si_o = 1'b0;
   end

   // nb: command bytes sent (1 opcode, 2 opcode+data, 4 opcode+addr, 5 all); nrd: bytes read
   task automatic frame(input spi_cmd_t c, input int nb, input int nrd, output logic [7:0] rd);
      logic [39:0] tx;
      int n;
      tx = (nb == 2) ? {c.opcode, c.data, 24'h00_0000} : c;
      n = 8 * (nb + nrd);
      rd = 8'h00;
      @(posedge clk_i);
      spi_cs_n_o <= 1'b0;
      for (int k = 0; k <= n; k++) begin
         repeat (4) @(posedge clk_i);
         // sampled just before the next falling edge, where the output is settled
         if (k > 8 * nb) rd = {rd[6:0], spi_so_i};
         spi_sck_o <= 1'b0;
         if (k == n) break;
         spi_si_o <= (k < 8 * nb) ? tx[39 - k] : 1'b0;
         repeat (4) @(posedge clk_i);
         spi_sck_o <= 1'b1;
      end
      repeat (4) @(posedge clk_i);
      spi_cs_n_o <= 1'b1;
      // released line does not keep its last value
      spi_si_o <= ~spi_si_o;
      repeat (8) @(posedge clk_i);
   endtask : frame
endmodule : flash_host

/* File: verification/flash_status_one_bench.sv */
`timescale 1ns/10ps
module flash_status_one_bench;
   import flash_status_pkg::*;
   localparam logic [7:0] PROG_CODE = 8'h02;
   localparam logic [7:0] ERASE_CODE = 8'hD8;
   localparam logic [7:0] BULK_CODE = 8'h60;
   localparam logic [7:0] SOFT_CODE = 8'hF0;
   localparam logic [7:0] OTP_CODE = 8'h42;
   logic clk_i, sys_rst_i, wp_n_i, hw_rst_n_i, otp_locked, array_done, array_fail;
   logic spi_sck, spi_cs_n, spi_si, spi_so, stored_write, array_start, suspend, so_oe, oe_seen;
   logic [7:0] stored_r, config_r, stored_data, status, last_sd, st_cnt, sw_cnt, sus_cnt;
   array_req_t array_req;
   int err_count, tests_run;

   flash_status_one uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sck_i(spi_sck), .spi_cs_n_i(spi_cs_n),
      .spi_si_i(spi_si), .wp_n_i(wp_n_i), .hw_rst_n_i(hw_rst_n_i), .status_one_stored_i(stored_r),
      .config_one_stored_i(config_r), .otp_locked_i(otp_locked), .array_done_i(array_done),
      .array_fail_i(array_fail), .spi_so_o(spi_so), .spi_so_oe_o(so_oe), .stored_write_o(stored_write),
      .stored_data_o(stored_data), .array_start_o(array_start), .array_req_o(array_req),
      .suspend_o(suspend), .status_one_volatile_o(status));

   flash_host host (.clk_i(clk_i), .spi_so_i(spi_so), .spi_sck_o(spi_sck), .spi_cs_n_o(spi_cs_n),
      .spi_si_o(spi_si));

   // stored register and engine side: count pulses, keep what gets written
   always @(posedge clk_i) begin
      if (array_start) st_cnt <= st_cnt + 8'h01;
      if (suspend) sus_cnt <= sus_cnt + 8'h01;
      if (so_oe) oe_seen <= 1'b1;
      if (stored_write) begin
         sw_cnt <= sw_cnt + 8'h01;
         last_sd <= stored_data;
         stored_r <= stored_data;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d, input int nb);
      logic [7:0] rd;
      host.frame('{op, a, d}, nb, 0, rd);
   endtask : cmd

   task automatic pulse_done(input logic f);
      @(posedge clk_i);
      array_done <= 1'b1;
      array_fail <= f;
      @(posedge clk_i);
      array_done <= 1'b0;
      array_fail <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse_done

   task automatic t_reset;
      logic [7:0] rd;
      chk(status, 8'h60);
      host.frame('{OP_RD_STATUS_ONE, 24'h00_0000, 8'h00}, 1, 2, rd);
      chk(rd, 8'h60);
      chk({7'h00, oe_seen}, 8'h01);
      chk({7'h00, so_oe}, 8'h00);
      host.frame('{OP_RD_ANY, 24'h80_0000, 8'h00}, 4, 1, rd);
      chk(rd, 8'h60);
      cmd(OP_CLR_B, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h00);
      stored_r <= 8'h80;
      repeat (3) @(posedge clk_i);
      chk(status, 8'h80);
      stored_r <= 8'h00;
      repeat (3) @(posedge clk_i);
      chk(status, 8'h00);
   endtask : t_reset

   task automatic t_latch;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h02);
      cmd(OP_WR_DIS, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h00);
      cmd(PROG_CODE, 24'h00_1234, 8'h00, 4);
      chk(st_cnt, 8'h00);
   endtask : t_latch

   task automatic t_program;
      logic [7:0] rd;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(PROG_CODE, 24'h00_1234, 8'h00, 4);
      chk(st_cnt, 8'h01);
      chk(status, 8'h03);
      chk({7'h00, array_req.kind == ARR_PROG}, 8'h01);
      chk(array_req.addr[7:0], 8'h34);
      cmd(OP_WR_DIS, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h03);
      host.frame('{OP_RD_STATUS_ONE, 24'h00_0000, 8'h00}, 1, 1, rd);
      chk(rd, 8'h03);
      pulse_done(1'b0);
      chk(status, 8'h00);
   endtask : t_program

   task automatic t_fail;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(ERASE_CODE, 24'h00_0000, 8'h00, 4);
      chk(st_cnt, 8'h02);
      cmd(OP_SUSP_A, 24'h00_0000, 8'h00, 1);
      chk(sus_cnt, 8'h01);
      pulse_done(1'b1);
      chk(status, 8'h23);
      cmd(OP_WR_DIS, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h23);
      // failed operation leaves the latch set: clear-status, then write-disable
      cmd(OP_CLR_A, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h02);
      cmd(OP_WR_DIS, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h00);
      cmd(OP_SUSP_B, 24'h00_0000, 8'h00, 1);
      chk(sus_cnt, 8'h01);
   endtask : t_fail

   task automatic t_stored;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(OP_WR_REGS, 24'h00_0000, 8'h0C, 2);
      chk(sw_cnt, 8'h01);
      chk(last_sd, 8'h0C);
      chk(status, 8'h0C);
   endtask : t_stored

   task automatic t_lock;
      stored_r <= 8'h8C;
      wp_n_i <= 1'b0;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(OP_WR_REGS, 24'h00_0000, 8'h00, 2);
      chk(sw_cnt, 8'h01);
      chk(status, 8'h8E);
      wp_n_i <= 1'b1;
      cmd(OP_WR_DIS, 24'h00_0000, 8'h00, 1);
      stored_r <= 8'h0C;
   endtask : t_lock

   task automatic t_volatile;
      config_r <= 8'h08;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(OP_WR_REGS, 24'h00_0000, 8'h1C, 2);
      chk(sw_cnt, 8'h01);
      chk(status, 8'h1C);
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(BULK_CODE, 24'h00_0000, 8'h00, 1);
      chk(st_cnt, 8'h02);
      chk(status & 8'h20, 8'h00);
      cmd(PROG_CODE, 24'hFF_FF00, 8'h00, 4);
      chk(st_cnt, 8'h02);
      chk(status & 8'h40, 8'h40);
   endtask : t_volatile

   task automatic t_any;
      logic [7:0] rd;
      cmd(SOFT_CODE, 24'h00_0000, 8'h00, 1);
      chk(status, 8'h0C);
      host.frame('{OP_RD_STATUS_TWO, 24'h00_0000, 8'h00}, 1, 1, rd);
      chk(rd, 8'h00);
      host.frame('{OP_RD_ANY, 24'h00_0000, 8'h00}, 4, 1, rd);
      chk(rd, 8'h00);
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(OP_WR_ANY, 24'h80_0000, 8'h04, 5);
      chk(status, 8'h04);
      chk(sw_cnt, 8'h01);
      otp_locked <= 1'b1;
      cmd(OP_WR_EN, 24'h00_0000, 8'h00, 1);
      cmd(OTP_CODE, 24'h00_0000, 8'h00, 4);
      chk(st_cnt, 8'h02);
      chk(status, 8'h47);
      otp_locked <= 1'b0;
   endtask : t_any

   task automatic t_hwrst;
      hw_rst_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      hw_rst_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(status, 8'h0C);
   endtask : t_hwrst

   task automatic stop_test;
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      sys_rst_i = 1'b1;
      wp_n_i = 1'b1;
      hw_rst_n_i = 1'b1;
      stored_r = 8'h60;
      config_r = 8'h00;
      otp_locked = 1'b0;
      array_done = 1'b0;
      array_fail = 1'b0;
      st_cnt = 8'h00;
      sw_cnt = 8'h00;
      sus_cnt = 8'h00;
      last_sd = 8'h00;
      oe_seen = 1'b0;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      t_reset();
      t_latch();
      t_program();
      t_fail();
      t_stored();
      t_lock();
      t_volatile();
      t_any();
      t_hwrst();
      stop_test();
   end

   // about 0.5 ms of traffic expected; generous margin
   initial begin
      #5_000_000;
      err_count++;
      stop_test();
   end
endmodule : flash_status_one_bench
